// ---- rtl/ipv_cfg.svh ----
// Constants of the interrupt priority and vectoring controller.
// Assumes APB register access with index * 4 as the byte address.
// Contract
// - Level from source's low and high bits
// - Four levels; high bit weighs two
// - Only strictly higher level preempts handler
// - Equal levels resolved by natural ranking
// - Sample and resolve flags every cycle; the code samples only while ce is high
// - No call while equal/higher level serviced
// - Call only on instruction's last cycle
// - Block call on interrupt return or priority write
// - Blocked requests are never remembered
// - Call pushes program counter, not status
// - Load vector; source stays in service
// - Interrupt return pops, clears service level
// - Plain return leaves service level set
// - Flag auto-clear on call per source
// - Priority registers reset to zero
// - Basic low register at B8, bits 6..0
// - Extended pair A at EF and F7
// - Extended pair B at FE/FF, bits 2..0
`ifndef IPV_CFG_SVH
`define IPV_CFG_SVH

`define IPV_IDX_HI_BASIC  8'hB7
`define IPV_IDX_LO_BASIC  8'hB8
`define IPV_IDX_LO_EXT_A  8'hEF
`define IPV_IDX_HI_EXT_A  8'hF7
`define IPV_IDX_LO_EXT_B  8'hFE
`define IPV_IDX_HI_EXT_B  8'hFF
`define IPV_IDX_STATUS    8'h10
`define IPV_IDX_CLEAR     8'h11
`define IPV_IDX_ENABLE    8'h12
`define IPV_IDX_SERVICE   8'h13

`define IPV_PRIO_RST      8'h00
`define IPV_MASK_BASIC    8'h7F
`define IPV_MASK_EXT_A    8'hFF
`define IPV_MASK_EXT_B    8'h07
`define IPV_AUTO_CLR      18'h10149
`define IPV_EV_CALL       0
`define IPV_EV_SPUR       1

`endif

// ---- rtl/ipv_pkg.sv ----
// Types of the interrupt priority and vectoring controller.
// Assumes ipv_cfg.svh supplies the constants.
package ipv_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ipv_apb_req_t;

  typedef struct packed {
    logic last;
    logic blocks;
    logic return_from_interrupt;
    logic ret;
  } ipv_instr_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] vector;
    logic [4:0]  source;
  } ipv_call_t;

  typedef struct packed {
    logic [7:0]  lo_basic;
    logic [7:0]  hi_basic;
    logic [7:0]  lo_ext_a;
    logic [7:0]  hi_ext_a;
    logic [7:0]  lo_ext_b;
    logic [7:0]  hi_ext_b;
    logic [17:0] smp;
    logic [3:0]  insvc;
    ipv_call_t   call;
    logic [17:0] fclr;
    logic [1:0]  sts;
    logic [1:0]  ena;
    logic        irq;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } ipv_state_t;

endpackage

// ---- rtl/ipv_ctrl.sv ----
// Interrupt priority resolution, vectoring call and in-service tracking.
// Assumes flags come already enable-gated from logic on pclk, and the core
// sequencer reports instruction boundaries and performs push and pop.
`timescale 1ns/1ns
`include "ipv_cfg.svh"
module ipv_ctrl #(
  parameter int NUM_SRC = 18
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire ipv_pkg::ipv_apb_req_t apb_req,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic [17:0]       src_flag,
  input  wire ipv_pkg::ipv_instr_t instr,
  output ipv_pkg::ipv_call_t     call,
  output logic [17:0]            flag_clr,
  output logic [3:0]             in_service,
  output logic                   irq
);
  import ipv_pkg::*;

  if (NUM_SRC != 18) begin : g_chk
    $error("ipv_ctrl serves exactly 18 sources");
  end

  // Natural ranking order: index 0 wins ties
  localparam logic [15:0] VEC [18] = '{
    16'h0003, 16'h0043, 16'h0053, 16'h000B, 16'h0033, 16'h005B,
    16'h0013, 16'h003B, 16'h001B, 16'h0023, 16'h0073, 16'h004B,
    16'h002B, 16'h0063, 16'h006B, 16'h007B, 16'h0083, 16'h008B};
  // Bit position of each source in {ext_b, ext_a, basic}
  localparam logic [4:0] PBIT [18] = '{
    5'h00, 5'h05, 5'h0C, 5'h01, 5'h08, 5'h06,
    5'h02, 5'h09, 5'h03, 5'h04, 5'h0D, 5'h0E,
    5'h0F, 5'h0A, 5'h0B, 5'h10, 5'h11, 5'h12};

  ipv_state_t st_ff;
  ipv_state_t nxt_st;

  logic [23:0] lo_all;
  logic [23:0] hi_all;
  logic        found;
  logic [1:0]  best_lvl;
  logic [4:0]  best_src;
  logic        blocked;
  logic        go;
  logic        setup;
  logic        wr_en;
  logic        prio_wr;
  logic [7:0]  idx;
  logic [3:0]  top_svc;
  logic        spur;

  assign lo_all = {st_ff.lo_ext_b, st_ff.lo_ext_a, st_ff.lo_basic};
  assign hi_all = {st_ff.hi_ext_b, st_ff.hi_ext_a, st_ff.hi_basic};
  assign idx    = apb_req.paddr[9:2];
  assign setup  = apb_req.psel && !apb_req.penable;
  assign wr_en  = apb_req.psel && apb_req.penable && st_ff.ready
                  && apb_req.pwrite && !st_ff.slverr;
  assign prio_wr = wr_en && (idx == `IPV_IDX_HI_BASIC || idx == `IPV_IDX_LO_BASIC
                   || idx == `IPV_IDX_LO_EXT_A || idx == `IPV_IDX_HI_EXT_A
                   || idx == `IPV_IDX_LO_EXT_B || idx == `IPV_IDX_HI_EXT_B);

  // Resolve the sampled flags every cycle; nothing is kept between polls
  always_comb begin
    found    = 1'b0;
    best_lvl = 2'h0;
    best_src = 5'h00;
    for (int i = 0; i < 18; i++) begin
      // High bit weighs two, low bit one
      if (st_ff.smp[i] && (!found || {hi_all[PBIT[i]], lo_all[PBIT[i]]} > best_lvl)) begin
        found    = 1'b1;
        best_lvl = {hi_all[PBIT[i]], lo_all[PBIT[i]]};
        best_src = 5'(i);
      end
    end
  end

  // Any level at or above the winner still in service blocks it
  assign blocked = (st_ff.insvc >> best_lvl) != 4'h0;
  // A priority write through the bus counts as a blocking instruction
  assign go = found && !blocked && instr.last
              && !instr.blocks && !instr.return_from_interrupt && !prio_wr;

  always_comb begin
    top_svc = 4'h0;
    for (int l = 0; l < 4; l++) begin
      if (st_ff.insvc[l]) begin
        top_svc = 4'(4'h1 << l);
      end
    end
  end
  assign spur = instr.return_from_interrupt && instr.last && st_ff.insvc == 4'h0;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.smp   = src_flag;
    nxt_st.call.valid = go;
    nxt_st.fclr  = 18'h00000;
    if (go) begin
      // The core pushes the return address only; status word is untouched
      nxt_st.call.vector = VEC[best_src];
      nxt_st.call.source = best_src;
      nxt_st.insvc = st_ff.insvc | 4'(4'h1 << best_lvl);
      nxt_st.fclr  = `IPV_AUTO_CLR & 18'(18'h1 << best_src);
    end else if (instr.return_from_interrupt && instr.last) begin
      nxt_st.insvc = st_ff.insvc & ~top_svc;
    end
    // A plain return leaves insvc alone, so its level stays blocked

    nxt_st.ready  = setup;
    nxt_st.slverr = 1'b0;
    if (setup) begin
      nxt_st.rdata  = 32'h0000_0000;
      nxt_st.slverr = apb_req.paddr[1:0] != 2'h0 || apb_req.paddr[11:10] != 2'h0;
      unique case (idx)
        `IPV_IDX_HI_BASIC: nxt_st.rdata[7:0] = st_ff.hi_basic;
        `IPV_IDX_LO_BASIC: nxt_st.rdata[7:0] = st_ff.lo_basic;
        `IPV_IDX_LO_EXT_A: nxt_st.rdata[7:0] = st_ff.lo_ext_a;
        `IPV_IDX_HI_EXT_A: nxt_st.rdata[7:0] = st_ff.hi_ext_a;
        `IPV_IDX_LO_EXT_B: nxt_st.rdata[7:0] = st_ff.lo_ext_b;
        `IPV_IDX_HI_EXT_B: nxt_st.rdata[7:0] = st_ff.hi_ext_b;
        `IPV_IDX_STATUS:   nxt_st.rdata[1:0] = st_ff.sts;
        `IPV_IDX_CLEAR:    nxt_st.rdata[1:0] = 2'h0;
        `IPV_IDX_ENABLE:   nxt_st.rdata[1:0] = st_ff.ena;
        `IPV_IDX_SERVICE:  nxt_st.rdata[3:0] = st_ff.insvc;
        default:           nxt_st.slverr = 1'b1;
      endcase
    end

    if (wr_en) begin
      unique case (idx)
        `IPV_IDX_HI_BASIC: nxt_st.hi_basic = apb_req.pwdata[7:0] & `IPV_MASK_BASIC;
        `IPV_IDX_LO_BASIC: nxt_st.lo_basic = apb_req.pwdata[7:0] & `IPV_MASK_BASIC;
        `IPV_IDX_LO_EXT_A: nxt_st.lo_ext_a = apb_req.pwdata[7:0] & `IPV_MASK_EXT_A;
        `IPV_IDX_HI_EXT_A: nxt_st.hi_ext_a = apb_req.pwdata[7:0] & `IPV_MASK_EXT_A;
        `IPV_IDX_LO_EXT_B: nxt_st.lo_ext_b = apb_req.pwdata[7:0] & `IPV_MASK_EXT_B;
        `IPV_IDX_HI_EXT_B: nxt_st.hi_ext_b = apb_req.pwdata[7:0] & `IPV_MASK_EXT_B;
        `IPV_IDX_CLEAR:    nxt_st.sts = st_ff.sts & ~apb_req.pwdata[1:0];
        `IPV_IDX_ENABLE:   nxt_st.ena = apb_req.pwdata[1:0];
        default:           nxt_st.sts = nxt_st.sts;
      endcase
    end
    // Events are set after the clear so a same-cycle event survives
    if (go) begin
      nxt_st.sts[`IPV_EV_CALL] = 1'b1;
    end
    if (spur) begin
      nxt_st.sts[`IPV_EV_SPUR] = 1'b1;
    end
    nxt_st.irq = |(nxt_st.sts & nxt_st.ena);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff          <= '0;
      st_ff.lo_basic <= `IPV_PRIO_RST;
      st_ff.hi_basic <= `IPV_PRIO_RST;
      st_ff.lo_ext_a <= `IPV_PRIO_RST;
      st_ff.hi_ext_a <= `IPV_PRIO_RST;
      st_ff.lo_ext_b <= `IPV_PRIO_RST;
      st_ff.hi_ext_b <= `IPV_PRIO_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign pready     = st_ff.ready;
  assign prdata     = st_ff.rdata;
  assign pslverr    = st_ff.slverr;
  assign call       = st_ff.call;
  assign flag_clr   = st_ff.fclr;
  assign in_service = st_ff.insvc;
  assign irq        = st_ff.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_accept;
    ce && go;
  endsequence
  sequence s_called;
    call.valid && flag_clr == (`IPV_AUTO_CLR & 18'(18'h1 << call.source));
  endsequence

  a_accept_calls: assert property (s_accept |=> s_called)
    else $error("accepted request gave no call");
  a_call_last_only: assert property (ce && !instr.last |=> !call.valid)
    else $error("call outside last instruction cycle");
  a_call_blocked: assert property (ce && (instr.blocks || instr.return_from_interrupt) |=> !call.valid)
    else $error("call during blocking instruction");
  a_top_level_busy: assert property (ce && in_service[3] |=> !call.valid)
    else $error("level 3 handler was preempted");
  a_vector_match: assert property (call.valid |-> call.vector == VEC[call.source])
    else $error("vector does not match source");
  a_call_marks_svc: assert property (s_accept |=> in_service[$past(best_lvl)])
    else $error("accepted level not marked in service");
  a_return_from_interrupt_clears: assert property (ce && instr.return_from_interrupt && instr.last && !go
    |=> in_service == ($past(in_service) & ~$past(top_svc)))
    else $error("return did not clear top level");
  a_ret_keeps: assert property (ce && !instr.return_from_interrupt && !go |=> $stable(in_service))
    else $error("service state changed without return");
  a_flags_sampled: assert property (ce && src_flag == 18'h00000 ##1 ce |=> !call.valid)
    else $error("call without a sampled flag");
  a_poll_fresh: assert property (ce |=> st_ff.smp == $past(src_flag))
    else $error("flags not sampled this cycle");
  a_prio_wr_blocks: assert property (ce && prio_wr |=> !call.valid)
    else $error("call in a priority write cycle");

endmodule

// ---- verification/ipv_core_model.sv ----
// Model of the flag sources and the core call stack around the controller.
// Assumes the bench raises and clears flags by mask, one cycle per request.
`timescale 1ns/1ns
module ipv_core_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [17:0]         raise,
  input  wire logic [17:0]         sw_clr,
  input  wire logic [17:0]         flag_clr,
  input  wire ipv_pkg::ipv_call_t  call,
  input  wire ipv_pkg::ipv_instr_t instr,
  output logic      [17:0]         src_flag,
  output logic      [3:0]          depth
);
  import ipv_pkg::*;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_flag <= 18'h00000;
      depth    <= 4'h0;
    end else begin
      // Flags not cleared by the call stay up until the handler clears them
      src_flag <= (src_flag | raise) & ~sw_clr & ~flag_clr;
      if (call.valid) begin
        depth <= depth + 4'h1;
      end else if (instr.return_from_interrupt && instr.last) begin
        depth <= depth - 4'h1;
      end
    end
  end
endmodule

// ---- verification/tb_ipv_ctrl.sv ----
// Self-checking bench of the priority and vectoring controller.
// Assumes the core model owns the flags; the bench is APB master and sequencer.
`timescale 1ns/1ns
`include "ipv_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_ipv_ctrl;
  import ipv_pkg::*;
  logic         pclk, presetn, pready, pslverr, irq, er, ce;
  ipv_apb_req_t req;
  ipv_instr_t   ins;
  ipv_call_t    call;
  logic [31:0]  prdata, rd, d;
  logic [17:0]  src_flag, flag_clr, raise, sw_clr;
  logic [3:0]   in_service, depth;
  logic [38:0]  exp_q[$];
  int           failures = 0, samples_checked = 0, cyc = 0, seed = 32'h4BF2;
  logic [17:0]  aut = `IPV_AUTO_CLR;
  logic [15:0]  vec[18] = '{16'h0003, 16'h0043, 16'h0053, 16'h000B, 16'h0033, 16'h005B,
    16'h0013, 16'h003B, 16'h001B, 16'h0023, 16'h0073, 16'h004B, 16'h002B, 16'h0063,
    16'h006B, 16'h007B, 16'h0083, 16'h008B};
  logic [7:0]   ridx[6] = '{8'hB7, 8'hB8, 8'hEF, 8'hF7, 8'hFE, 8'hFF};
  logic [7:0]   rmsk[6] = '{8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'h07, 8'h07};
  ipv_ctrl u_ipv_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .src_flag(src_flag), .instr(ins),
    .call(call), .flag_clr(flag_clr), .in_service(in_service), .irq(irq));
  ipv_core_model u_ipv_core_model (.pclk(pclk), .presetn(presetn), .raise(raise),
    .sw_clr(sw_clr), .flag_clr(flag_clr), .call(call), .instr(ins), .src_flag(src_flag),
    .depth(depth));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, {2'b00, ix, 2'b00}, wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    rd = prdata;
    er = pslverr;
    req <= '0;
  endtask
  // Instruction bits are last, blocks, return_from_interrupt, ret; idle cycles let the call land
  task automatic step(input logic [3:0] i);
    @(posedge pclk);
    ins <= i;
    @(posedge pclk);
    ins <= '0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic fl(input logic [17:0] up, input logic [17:0] dn);
    @(posedge pclk);
    raise  <= up;
    sw_clr <= dn;
    @(posedge pclk);
    raise  <= '0;
    sw_clr <= '0;
    repeat (2) @(posedge pclk);
  endtask
  function automatic void push(input int s);
    exp_q.push_back({vec[s], 5'(s), (18'h00001 << s) & aut});
  endfunction
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin failures++; final_report(); end
    if (call.valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(call.valid, 1'b0)
      else `CHK({call.vector, call.source, flag_clr}, exp_q.pop_front())
    end
  end
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0; req = '0; ins = '0; raise = '0; sw_clr = '0; ce = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      d = $random(seed);
      apb(1'b0, ridx[k], 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, ridx[k], d);
      apb(1'b0, ridx[k], 32'h0);
      `CHK(rd, {24'h0, d[7:0] & rmsk[k]})
      apb(1'b1, ridx[k], 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    `CHK(er, 1'b1)
    $display("registers done");
    for (int s = 0; s < 18; s++) begin
      fl(18'h00001 << s, 18'h0);
      push(s);
      step(4'h8);
      `CHK(in_service, 4'h1)
      `CHK(depth, 4'h1)
      `CHK(src_flag[s], ~aut[s])
      fl(18'h0, 18'h00001 << s);
      step(4'hA);
      `CHK({in_service, depth}, 8'h00)
    end
    `CHK(irq, 1'b0)
    $display("vectors done");
    fl(18'h3FFFF, 18'h0);
    push(0);
    step(4'h8);
    step(4'h8);
    step(4'h9);
    `CHK(in_service, 4'h1)
    step(4'hA);
    step(4'hC);
    step(4'h0);
    push(1);
    step(4'h8);
    `CHK(exp_q.size(), 0)
    fl(18'h0, 18'h3FFFF);
    step(4'hA);
    fl(18'h00020, 18'h0);
    step(4'hC);
    fl(18'h0, 18'h00020);
    step(4'h8);
    `CHK(in_service, 4'h0)
    $display("blocking done");
    apb(1'b1, `IPV_IDX_LO_BASIC, 32'h2);
    apb(1'b1, `IPV_IDX_HI_BASIC, 32'h1);
    apb(1'b1, `IPV_IDX_LO_EXT_B, 32'h4);
    apb(1'b1, `IPV_IDX_HI_EXT_B, 32'h4);
    fl(18'h0000A, 18'h0);
    push(3);
    step(4'h8);
    `CHK(in_service, 4'h2)
    fl(18'h20001, 18'h0);
    push(17);
    step(4'h8);
    `CHK(in_service, 4'hA)
    step(4'h8);
    fl(18'h0, 18'h20000);
    step(4'hA);
    `CHK(in_service, 4'h2)
    push(0);
    step(4'h8);
    `CHK(in_service, 4'h6)
    fl(18'h0, 18'h3FFFF);
    repeat (3) step(4'hA);
    `CHK(irq, 1'b0)
    apb(1'b1, `IPV_IDX_ENABLE, 32'h3);
    // The enable commits at the edge the task returns on; irq settles after it
    @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b0, `IPV_IDX_STATUS, 32'h0);
    `CHK(rd, 32'h3)
    apb(1'b1, `IPV_IDX_CLEAR, 32'h3);
    apb(1'b0, `IPV_IDX_STATUS, 32'h0);
    `CHK({rd[1:0], irq}, 3'h0)
    // Clock enable low freezes the poll, so a last cycle then gives no call
    @(posedge pclk) ce <= 1'b0;
    fl(18'h00008, 18'h0);
    step(4'h8);
    `CHK(in_service, 4'h0)
    @(posedge pclk) ce <= 1'b1;
    push(3);
    step(4'h8);
    `CHK(in_service, 4'h2)
    `CHK(exp_q.size(), 0)
    $display("levels and interrupt done");
    final_report();
  end
endmodule
